// File: common/drb_defs.svh
// Constants for the read burst sequencing link: offsets, field positions, timing counts.
`ifndef DRB_DEFS_SVH
`define DRB_DEFS_SVH

`define DRB_PIPE_DEPTH   64
`define DRB_ADDR_W       14
`define DRB_COL_W        10
`define DRB_AP_BIT       10
`define DRB_BSEL_BIT     12
`define DRB_MR_BL_LSB    0
`define DRB_MR_CL_LSB    2
`define DRB_MR_AL_LSB    7
`define DRB_MR_PRE2_BIT  12
`define DRB_BL_FIXED8    2'b00
`define DRB_BL_OTF       2'b01
`define DRB_BL_CHOP4     2'b10
`define DRB_RBL_EIGHT    4'h8
`define DRB_RBL_FOUR     4'h4
`define DRB_RL_MIN       6'h03
`define DRB_CCD_MIN      8'h04
`define DRB_CCD_PRE2_BAD 8'h05
`define DRB_CWL_LOWEST   5'h09
`define DRB_CL_RESET     5'h0b
`define DRB_CWL_RESET    5'h09
`define DRB_CK_HALF      3'h4
`define DRB_REG_CMD      8'h00
`define DRB_REG_CFG      8'h04
`define DRB_REG_STATUS   8'h08
`define DRB_REG_RDATA    8'h0c
`define DRB_CMD_OP_LSB   0
`define DRB_CMD_BG_LSB   3
`define DRB_CMD_ADDR_LSB 16
`define DRB_CFG_WPRE2    5

`endif

// File: common/drb_if.sv
// Link between the memory controller end and the memory device end.
`include "drb_defs.svh"
interface drb_if;
   import drb_pkg::*;

   logic                   ck;
   drb_cmd_e               cmd;
   logic [1:0]             bg;
   logic [`DRB_ADDR_W-1:0] addr;
   logic                   dqsOe;
   logic                   dqsRun;
   logic                   dqOe;
   logic [15:0]            dqPair;

   modport ctrl (output ck, cmd, bg, addr, input dqsOe, dqsRun, dqOe, dqPair);
   modport dev  (input ck, cmd, bg, addr, output dqsOe, dqsRun, dqOe, dqPair);
endinterface : drb_if

// File: common/drb_pkg.sv
// Types shared by both ends of the read burst sequencing link.
`include "drb_defs.svh"
package drb_pkg;

   typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_MRS} drb_cmd_e;

   typedef struct packed {
      logic                  start;
      logic                  chop;
      logic                  ap;
      logic [1:0]            bg;
      logic [`DRB_COL_W-1:0] col;
   } drb_slot_s;

   function automatic logic [15:0] drb_beat_pair(input logic [`DRB_COL_W-1:0] col,
                                                 input logic [2:0] beat);
      logic [7:0] b0;
      b0 = col[7:0] + {5'h00, beat};
      return {b0 + 8'h01, b0};
   endfunction : drb_beat_pair

endpackage : drb_pkg

// File: rtl/drb_ctrl.sv
// Memory controller end: APB registers, link clock divider, command spacing, read capture.
`include "drb_defs.svh"
module drb_ctrl
   import drb_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   drb_if.ctrl              link
);

   typedef struct packed {
      logic [2:0]             phase;
      logic                   ck;
      drb_cmd_e               cmd;
      logic [1:0]             bg;
      logic [`DRB_ADDR_W-1:0] addr;
      logic                   pend;
      drb_cmd_e               pOp;
      logic [1:0]             pBg;
      logic [`DRB_ADDR_W-1:0] pAddr;
      logic [7:0]             sinceRead;
      logic [3:0]             lastRbl;
      logic [1:0]             burstMode;
      logic [4:0]             cl;
      logic                   pre2;
      logic [4:0]             write_cas_latency;
      logic                   wpre2;
      logic                   pready;
      logic                   pslverr;
      logic [31:0]            prdata;
      logic [16:0]            sy1;
      logic [16:0]            sy2;
      logic [15:0]            rdPair;
      logic [15:0]            pairCount;
   } drb_ctl_s;

   drb_ctl_s st_q;
   drb_ctl_s st_d;

   logic [7:0] wrGap;
   logic       issueOk;
   logic [2:0] opCode;

   function automatic logic [7:0] rd_to_wr_gap(input logic [4:0] cl, input logic [4:0] write_cas_latency,
                                               input logic [3:0] read_burst_count, input logic wpre2);
      int g;
      g = int'(cl) - int'(write_cas_latency) + int'(read_burst_count) / 2 + 1 + (wpre2 ? 2 : 1);
      return (g < 0) ? 8'h00 : g[7:0];
   endfunction : rd_to_wr_gap

   always_comb
   begin
      st_d    = st_q;
      opCode  = pwdata[`DRB_CMD_OP_LSB +: 3];
      wrGap   = rd_to_wr_gap(st_q.cl, st_q.write_cas_latency, st_q.lastRbl, st_q.wpre2); // RULE14
      issueOk = 1'b1;
      st_d.sy1 = {link.dqOe, link.dqPair};
      st_d.sy2 = st_q.sy1;
      st_d.phase = (st_q.phase == 3'd7) ? 3'd0 : st_q.phase + 3'd1;
      st_d.ck    = (st_d.phase < `DRB_CK_HALF);
      if (st_d.phase == 3'd0 && st_q.sinceRead != 8'hff)
      begin
         st_d.sinceRead = st_q.sinceRead + 8'h01;
      end
      if (st_q.pOp == CMD_READ)
      begin
         issueOk = (st_q.sinceRead >= `DRB_CCD_MIN) &&
                   !(st_q.pre2 && st_q.sinceRead == `DRB_CCD_PRE2_BAD); // RULE6 RULE9
      end
      else if (st_q.pOp == CMD_WRITE)
      begin
         issueOk = (st_q.sinceRead >= wrGap); // RULE11 RULE12
      end
      if (st_d.phase == `DRB_CK_HALF)
      begin
         st_d.cmd = CMD_NOP;
         if (st_q.pend && issueOk)
         begin
            st_d.cmd  = st_q.pOp;
            st_d.bg   = st_q.pBg;
            st_d.addr = st_q.pAddr;
            st_d.pend = 1'b0;
            if (st_q.pOp == CMD_READ)
            begin
               st_d.sinceRead = 8'h00;
               if (st_q.burstMode == `DRB_BL_OTF)
               begin
                  st_d.lastRbl = st_q.pAddr[`DRB_BSEL_BIT] ? `DRB_RBL_EIGHT
                                                            : `DRB_RBL_FOUR; // RULE15
               end
               else
               begin
                  st_d.lastRbl = (st_q.burstMode == `DRB_BL_CHOP4) ? `DRB_RBL_FOUR
                                                                    : `DRB_RBL_EIGHT;
               end
            end
            if (st_q.pOp == CMD_MRS)
            begin
               st_d.burstMode = st_q.pAddr[`DRB_MR_BL_LSB +: 2]; // RULE4
               st_d.cl        = st_q.pAddr[`DRB_MR_CL_LSB +: 5];
               st_d.pre2      = st_q.pAddr[`DRB_MR_PRE2_BIT];
            end
         end
      end
      if (st_q.phase == 3'd6 && st_q.sy2[16])
      begin
         st_d.rdPair    = st_q.sy2[15:0];
         st_d.pairCount = st_q.pairCount + 16'h0001;
      end
      st_d.pready  = 1'b0;
      st_d.pslverr = 1'b0;
      if (psel && !penable && !st_q.pready)
      begin
         st_d.pready = 1'b1;
         st_d.prdata = '0;
         unique case (paddr)
            `DRB_REG_CMD:    st_d.prdata = {2'b00, st_q.pAddr, 11'h000, st_q.pBg, st_q.pOp};
            `DRB_REG_CFG:    st_d.prdata = {26'h0, st_q.wpre2, st_q.write_cas_latency};
            `DRB_REG_STATUS: st_d.prdata = {16'h0, st_q.sinceRead, 6'h00,
                                 st_q.wpre2 && st_q.write_cas_latency <= `DRB_CWL_LOWEST, st_q.pend}; // RULE13
            `DRB_REG_RDATA:  st_d.prdata = {st_q.pairCount, st_q.rdPair};
            default:         st_d.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && st_q.pready && pwrite && !st_q.pslverr)
      begin
         if (paddr == `DRB_REG_CMD && !st_q.pend)
         begin
            st_d.pend  = 1'b1;
            st_d.pOp   = (opCode <= 3'd4) ? drb_cmd_e'(opCode) : CMD_NOP;
            st_d.pBg   = pwdata[`DRB_CMD_BG_LSB +: 2];
            st_d.pAddr = pwdata[`DRB_CMD_ADDR_LSB +: `DRB_ADDR_W];
         end
         if (paddr == `DRB_REG_CFG)
         begin
            st_d.write_cas_latency   = pwdata[4:0];
            st_d.wpre2 = pwdata[`DRB_CFG_WPRE2];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q           <= '0;
         st_q.phase     <= 3'd7;
         st_q.sinceRead <= 8'hff;
         st_q.lastRbl   <= `DRB_RBL_EIGHT;
         st_q.cl        <= `DRB_CL_RESET;
         st_q.write_cas_latency       <= `DRB_CWL_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign prdata    = st_q.prdata;
   assign pready    = st_q.pready;
   assign pslverr   = st_q.pslverr;
   assign link.ck   = st_q.ck;
   assign link.cmd  = st_q.cmd;
   assign link.bg   = st_q.bg;
   assign link.addr = st_q.addr;

endmodule : drb_ctrl

// File: rtl/drb_device.sv
// Memory device end: read commands, latency pipeline, preamble and burst output.
//
// Rules of the link, kept across both ends
// RULE1 - Burst select bit picks chop or eight.
// RULE2 - Plain read leaves the bank open.
// RULE3 - Auto precharge read closes bank after burst.
// RULE4 - Mode bits pick fixed eight, per-command, chop.
// RULE5 - First beat arrives additive plus cas latency.
// RULE6 - Eight-beat reads four apart stream seamlessly.
// RULE7 - Mixed lengths four apart use own length.
// RULE8 - Wider spacing leaves gap, preamble re-driven.
// RULE9 - Two-clock preamble forbids spacing of five.
// RULE10 - Preamble lasts one or two clocks.
// RULE11 - Eight-beat read to write needs eight clocks.
// RULE12 - Chopped read to write needs six clocks.
// RULE13 - Two-clock write preamble wants higher write latency.
// RULE14 - Read to write spacing follows latency formula.
// RULE15 - Read burst count is eight or four.
// RULE16 - Two beats per clock, chop gives four.
`include "drb_defs.svh"
module drb_device
   import drb_pkg::*;
(
   drb_if.dev               link,
   input  wire logic        reset_n,
   output logic [3:0]       bankOpen,
   output logic [1:0]       burstMode,
   output logic [5:0]       readLatency
);

   typedef struct packed {
      drb_slot_s [`DRB_PIPE_DEPTH-1:0] pipe;
      logic [3:0]                      bankOpen;
      logic [1:0]                      burstMode;
      logic [4:0]                      cl;
      logic [4:0]                      al;
      logic                            pre2;
      logic [5:0]                      rl;
      logic [1:0]                      left;
      logic                            curAp;
      logic [1:0]                      curBg;
      logic                            curChop;
      logic [`DRB_COL_W-1:0]           curCol;
      logic [2:0]                      beat;
      logic                            dqsOe;
      logic                            dqsRun;
      logic                            dqOe;
      logic [15:0]                     dqPair;
   } drb_dev_s;

   drb_dev_s st_q;
   drb_dev_s st_d;

   drb_slot_s  slot;
   logic [5:0] insertAt;
   logic [5:0] rlNew;
   logic       dataNext;

   always_comb
   begin
      st_d     = st_q;
      slot     = '0;
      insertAt = '0;
      rlNew    = '0;
      dataNext = 1'b0;

      // Every scheduled burst moves one clock nearer to the data bus.
      for (int i = 0; i < `DRB_PIPE_DEPTH - 1; i++)
      begin
         st_d.pipe[i] = st_q.pipe[i + 1];
      end
      st_d.pipe[`DRB_PIPE_DEPTH-1] = '0;

      // The bank of an auto precharge read closes after its last data clock.
      if (st_q.dqsRun && (st_q.left == 2'd0) && st_q.curAp)
      begin
         st_d.bankOpen[st_q.curBg] = 1'b0; // RULE3
      end

      unique case (link.cmd)
         CMD_ACT:
         begin
            st_d.bankOpen[link.bg] = 1'b1;
         end
         CMD_READ:
         begin
            slot.start = 1'b1;
            slot.bg    = link.bg;
            slot.col   = link.addr[`DRB_COL_W-1:0];
            slot.ap    = link.addr[`DRB_AP_BIT]; // RULE2 RULE3
            if (st_q.burstMode == `DRB_BL_OTF)
            begin
               slot.chop = ~link.addr[`DRB_BSEL_BIT]; // RULE1 RULE7
            end
            else
            begin
               slot.chop = (st_q.burstMode == `DRB_BL_CHOP4); // RULE4
            end
            insertAt = st_q.rl - 6'h01; // RULE5
            st_d.pipe[insertAt] = slot;
         end
         CMD_MRS:
         begin
            st_d.burstMode = link.addr[`DRB_MR_BL_LSB +: 2]; // RULE4
            st_d.cl        = link.addr[`DRB_MR_CL_LSB +: 5];
            st_d.al        = link.addr[`DRB_MR_AL_LSB +: 5];
            st_d.pre2      = link.addr[`DRB_MR_PRE2_BIT];
            rlNew          = {1'b0, st_d.cl} + {1'b0, st_d.al}; // RULE5
            st_d.rl        = (rlNew < `DRB_RL_MIN) ? `DRB_RL_MIN : rlNew;
         end
         default:
         begin
         end
      endcase

      st_d.dqsOe  = 1'b0;
      st_d.dqsRun = 1'b0;
      st_d.dqOe   = 1'b0;
      st_d.dqPair = '0;

      if (st_q.pipe[0].start)
      begin
         // A new burst starts here, taking over directly from any burst ending now.
         dataNext     = 1'b1;
         st_d.curAp   = st_q.pipe[0].ap;
         st_d.curBg   = st_q.pipe[0].bg;
         st_d.curChop = st_q.pipe[0].chop;
         st_d.curCol  = st_q.pipe[0].col;
         st_d.beat    = 3'd0;
         st_d.left    = st_q.pipe[0].chop ? 2'd1 : 2'd3; // RULE15 RULE16
         st_d.dqPair  = drb_beat_pair(st_q.pipe[0].col, 3'd0); // RULE6
      end
      else if (st_q.left != 2'd0)
      begin
         dataNext    = 1'b1;
         st_d.left   = st_q.left - 2'd1;
         st_d.beat   = st_q.beat + 3'd2;
         st_d.dqPair = drb_beat_pair(st_q.curCol, st_q.beat + 3'd2); // RULE16
      end

      if (dataNext)
      begin
         st_d.dqsOe  = 1'b1;
         st_d.dqsRun = 1'b1;
         st_d.dqOe   = 1'b1;
      end
      else if (st_q.pipe[1].start || (st_q.pre2 && st_q.pipe[2].start))
      begin
         // The strobe is driven without toggling ahead of a burst after idle.
         st_d.dqsOe = 1'b1; // RULE8 RULE10
      end
   end

   always_ff @(posedge link.ck or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q           <= '0;
         st_q.cl        <= `DRB_CL_RESET;
         st_q.rl        <= {1'b0, `DRB_CL_RESET};
         st_q.burstMode <= `DRB_BL_FIXED8;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign link.dqsOe   = st_q.dqsOe;
   assign link.dqsRun  = st_q.dqsRun;
   assign link.dqOe    = st_q.dqOe;
   assign link.dqPair  = st_q.dqPair;
   assign bankOpen     = st_q.bankOpen;
   assign burstMode    = st_q.burstMode;
   assign readLatency  = st_q.rl;

endmodule : drb_device

// File: test/drb_link_assertions.sv
// Link checker for read latency, burst length, strobe framing and read spacing.
`include "drb_defs.svh"
module drb_link_assertions
   import drb_pkg::*;
(
   input wire logic        ck,
   input wire logic        reset_n,
   input wire logic [2:0]  cmd,
   input wire logic [1:0]  bg,
   input wire logic [13:0] addr,
   input wire logic        dqsOe,
   input wire logic        dqsRun,
   input wire logic        dqOe,
   input wire logic [15:0] dqPair
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [63:0] rdQ;
   logic [63:0] chQ;
   logic [1:0]  modeQ;
   logic [4:0]  clQ;
   logic [4:0]  alQ;
   logic        pre2Q;
   logic [1:0]  remQ;
   logic [5:0]  rl;
   logic        hit;
   logic        chop;

   assign rl   = {1'b0, clQ} + {1'b0, alQ};
   assign hit  = rdQ[0];
   assign chop = modeQ == `DRB_BL_CHOP4 || (modeQ == `DRB_BL_OTF && !addr[`DRB_BSEL_BIT]);

   // Tracks the mode settings and counts each read down to its own first data cycle.
   always_ff @(posedge ck or negedge reset_n)
      if (!reset_n)
      begin
         rdQ <= '0;
         chQ <= '0;
         modeQ <= `DRB_BL_FIXED8;
         clQ <= `DRB_CL_RESET;
         alQ <= 5'h00;
         pre2Q <= 1'b0;
         remQ <= 2'h0;
      end
      else
      begin
         rdQ <= {1'b0, rdQ[63:1]} | ((cmd == CMD_READ) ? (64'h1 << rl) : 64'h0);
         chQ <= {1'b0, chQ[63:1]} | ((cmd == CMD_READ && chop) ? (64'h1 << rl) : 64'h0);
         if (cmd == CMD_MRS)
         begin
            modeQ <= addr[1:0];
            clQ <= addr[6:2];
            alQ <= addr[11:7];
            pre2Q <= addr[12];
         end
         if (hit)
            remQ <= chQ[0] ? 2'h1 : 2'h3;
         else if (remQ != 2'h0)
            remQ <= remQ - 2'h1;
      end

   default clocking dc @(posedge ck);
   endclocking
   default disable iff (!reset_n);

   property p_lat;
      hit |-> dqOe && dqsRun;
   endproperty
   a_lat: assert property (p_lat) else $error("no data at read latency");
   property p_len;
      dqOe == (hit || remQ != 2'h0);
   endproperty
   a_len: assert property (p_len) else $error("burst length wrong");
   property p_pre;
      $rose(dqOe) |-> $past(dqsOe) && !$past(dqsRun);
   endproperty
   a_pre: assert property (p_pre) else $error("preamble missing");
   property p_pre2;
      $rose(dqOe) && pre2Q |-> $past(dqsOe, 2) && !$past(dqsRun, 2);
   endproperty
   a_pre2: assert property (p_pre2) else $error("long preamble missing");
   property p_run;
      dqOe |-> dqsOe && dqsRun;
   endproperty
   a_run: assert property (p_run) else $error("strobe stopped in burst");
   property p_idle;
      !dqsOe |-> !dqOe && dqPair == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("data driven while idle");
   property p_gap;
      cmd == CMD_READ |=> (cmd != CMD_READ) [*3];
   endproperty
   a_gap: assert property (p_gap) else $error("reads too close");
   property p_five;
      cmd == CMD_READ && pre2Q |-> ##5 cmd != CMD_READ;
   endproperty
   a_five: assert property (p_five) else $error("read five apart");
   c_chop: cover property (hit && chQ[0]);
   c_seam: cover property (hit && $past(dqOe));
   c_pre2: cover property ($rose(dqOe) && pre2Q);
endmodule : drb_link_assertions

// File: test/tb_top.sv
// Testbench joining the controller and device ends, driven over APB.
`include "drb_defs.svh"
module tb_top
   import drb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  bankOpen;
   logic [1:0]  burstMode;
   logic [5:0]  readLatency;
   logic [31:0] r;
   logic        e;
   logic [15:0] expCnt = 16'h0;
   logic [15:0] expPair;
   logic [7:0]  mn;
   int          n_errors = 0;
   int          checked = 0;

   always #4 sys_clk = ~sys_clk;

   drb_if lnk();
   drb_ctrl drb_ctrl_i(.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(lnk));
   drb_device drb_device_i(.link(lnk), .reset_n(reset_n), .bankOpen(bankOpen),
      .burstMode(burstMode), .readLatency(readLatency));
   drb_link_assertions drb_link_assertions_i(.ck(lnk.ck), .reset_n(reset_n), .cmd(lnk.cmd),
      .bg(lnk.bg), .addr(lnk.addr), .dqsOe(lnk.dqsOe), .dqsRun(lnk.dqsRun), .dqOe(lnk.dqOe),
      .dqPair(lnk.dqPair));

   task finish_test;
      if (n_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge sys_clk);
         i++;
      end
      while (pready !== 1'b1 && i < 50);
      if (pready !== 1'b1)
      begin
         n_errors++;
         finish_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      int i;
      i = 0;
      do
      begin
         apb(1'b0, a, 32'h0);
         i++;
      end
      while ((r & m) !== v && i < 400);
      if ((r & m) !== v)
      begin
         n_errors++;
         finish_test();
      end
   endtask : poll

   task issue(input logic [2:0] op, input logic [1:0] g, input logic [13:0] ad);
      apb(1'b1, `DRB_REG_CMD, {2'h0, ad, 11'h000, g, op});
      poll(`DRB_REG_STATUS, 32'h1, 32'h0);
      // Lets one full link clock pass so the device has sampled the command.
      repeat (8) @(posedge sys_clk);
   endtask : issue

   task mrs(input logic [1:0] m, input logic [4:0] cl, input logic [4:0] al, input logic p2);
      issue(3'h4, 2'h0, {1'b0, p2, al, cl, m});
   endtask : mrs

   task rdb(input logic [1:0] g, input logic [7:0] c, input logic s, input logic ap,
            input logic ch);
      issue(3'h2, g, {1'b0, s, 1'b0, ap, 2'h0, c});
      expCnt = expCnt + (ch ? 16'h0002 : 16'h0004);
      expPair = ch ? {c + 8'h03, c + 8'h02} : {c + 8'h07, c + 8'h06};
   endtask : rdb

   task drain;
      poll(`DRB_REG_RDATA, 32'hffff0000, {expCnt, 16'h0000});
      chk(r, {expCnt, expPair});
   endtask : drain

   initial
   begin
      reset_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      apb(1'b0, `DRB_REG_CFG, 32'h0);
      chk(r, 32'h00000009);
      chk({bankOpen, burstMode, readLatency}, {4'h0, 2'h0, 6'h0b});
      apb(1'b0, 8'h10, 32'h0);
      chk({e, r[30:0]}, 32'h80000000);
      mrs(2'h1, 5'h0b, 5'h00, 1'b0);
      chk({burstMode, readLatency}, {2'h1, 6'h0b});
      issue(3'h1, 2'h0, 14'h0);
      issue(3'h1, 2'h1, 14'h0);
      chk(bankOpen, 4'h3);
      rdb(2'h0, 8'h10, 1'b1, 1'b0, 1'b0);
      drain();
      rdb(2'h1, 8'h20, 1'b0, 1'b0, 1'b1);
      drain();
      for (int i = 0; i < 8; i++)
         rdb({1'b0, i[0]}, 8'h40 + 8'(i * 16), i < 4 || i[0], 1'b0, i >= 4 && !i[0]);
      drain();
      rdb(2'h0, 8'h30, 1'b1, 1'b0, 1'b0);
      repeat (48) @(posedge sys_clk);
      rdb(2'h1, 8'h38, 1'b1, 1'b1, 1'b0);
      drain();
      chk(bankOpen, 4'h1);
      mrs(2'h0, 5'h0b, 5'h0a, 1'b1);
      chk({burstMode, readLatency}, {2'h0, 6'h15});
      rdb(2'h0, 8'h50, 1'b0, 1'b0, 1'b0);
      rdb(2'h0, 8'h58, 1'b0, 1'b0, 1'b0);
      drain();
      for (int k = 0; k < 3; k++)
      begin
         apb(1'b1, `DRB_REG_CFG, k == 2 ? 32'h29 : 32'h09);
         mrs(k == 0 ? 2'h2 : 2'h0, 5'h0b, 5'h00, 1'b0);
         mn = k == 0 ? 8'h06 : (k == 1 ? 8'h08 : 8'h09);
         rdb(2'h0, 8'h70, 1'b1, 1'b0, k == 0);
         issue(3'h3, 2'h1, 14'h0);
         apb(1'b0, `DRB_REG_STATUS, 32'h0);
         chk({r[1], r[15:8] >= mn && r[15:8] <= mn + 8'h02}, {k == 2, 1'b1});
         drain();
      end
      finish_test();
   end
endmodule : tb_top
